// File: bench/shtl_highway_model.sv
// far side of the highway: shared bit clock, frame sync and receive data
`default_nettype none

module shtl_highway_model
  import shtl_pkg::*;
#(
  parameter int HOLD_OFF = 1000,
  parameter int FRAME_BITS = SLOT_BITS * SLOT_COUNT
) (
  // reset as seen by the surroundings
  input wire logic reset,
  // highway clock, sync and receive line
  output logic txBitClock,
  output logic txSyncPulse,
  output logic serialRxPin
);
  timeunit 1ns;
  timeprecision 100ps;

  int seed = 37178;
  int holdCnt = 0;
  int bitCnt = 0;
  int r;

  // ****************************************************
  // clock and frame
  // ****************************************************
  // one clock
  // one clock
  // the one free-running clock serves both directions, so the two bit clocks can never differ
  initial begin
    txBitClock = 1'b0;
    txSyncPulse = 1'b0;
    serialRxPin = 1'b0;
    #3;
    forever #16 txBitClock = ~txBitClock;
  end

  // equal rates
  // a single sync serves both directions; every slot carries a full byte each way
  always @(negedge txBitClock) begin
    r = $random(seed);
    serialRxPin <= r[0];  // live traffic in every slot, never a stale level
    if (reset) begin
      holdCnt <= 0;
    end else if (holdCnt < HOLD_OFF) begin
      holdCnt <= holdCnt + 1;
    end
    bitCnt <= (bitCnt == FRAME_BITS - 1) ? 0 : bitCnt + 1;
    txSyncPulse <= (holdCnt >= HOLD_OFF) && (bitCnt == 0);
  end
endmodule : shtl_highway_model

`default_nettype wire

// File: bench/shtl_test_loops_test.sv
// self-checking bench for the serial highway test loops
`default_nettype none

module shtl_test_loops_test
  import shtl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic coreClk, reset, actionPulse, formatterTxBit;
  logic [31:0] actionSpecWord;
  logic [CHAN_W-1:0] loopChannel;
  logic eventQueueValid, irqOut, loopRefused, txBitClock, txSyncPulse, serialRxPin, serialTxPin, rxPathBit;
  logic [31:0] eventQueueEntry;
  logic [LOOP_FIELD_W-1:0] loopState;
  int seed = 37178;
  int numErrors = 0;
  int nTests = 0;
  int ackCount = 0;
  int settle = 0;
  int fr;
  logic [35:0] ackQ[$];
  logic [35:0] expNote;
  shtl_loop_t curLoop = LOOP_NONE;
  logic [CHAN_W-1:0] curChan = 5'h00;
  bit chkEn = 0;
  bit rxS1, rxS2, syncS1, syncS2, fmt, rxd, hit;
  logic [15:0] hwFormat = 16'h0000;
  logic [1:0] expOut;
  logic [7:0] pos = 8'h00;

  shtl_test_loops dut (.core_clk(coreClk), .reset(reset), .actionPulse(actionPulse),
    .actionSpecWord(actionSpecWord), .loopChannel(loopChannel), .eventQueueValid(eventQueueValid),
    .eventQueueEntry(eventQueueEntry), .irqOut(irqOut), .loopState(loopState), .loopRefused(loopRefused),
    .txBitClock(txBitClock), .txSyncPulse(txSyncPulse), .serialRxPin(serialRxPin),
    .formatterTxBit(formatterTxBit), .serialTxPin(serialTxPin), .rxPathBit(rxPathBit));

  shtl_highway_model far (.reset(reset), .txBitClock(txBitClock), .txSyncPulse(txSyncPulse),
    .serialRxPin(serialRxPin));

  // ****************************************************
  // helpers
  // ****************************************************
  // core clock, 8 ns
  initial begin
    coreClk = 1'b0;
    forever #4 coreClk = ~coreClk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      numErrors++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d, mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // expected pin and receive-path bit for one edge, given the commanded loop
  function automatic logic [1:0] route(input shtl_loop_t l, input logic f, input logic r, input logic hit);
    case (l)
      LOOP_INT_FULL: return {f, f};
      LOOP_INT_CHAN: return {f, hit ? f : r};
      LOOP_EXT_FULL: return {r, r};
      LOOP_EXT_CHAN: return {hit ? r : f, r};
      default: return {f, r};
    endcase
  endfunction : route

  // one action request; the expected acknowledge is noted before the pulse
  task automatic act(input logic [7:0] lowByte, input shtl_loop_t expLoop, input logic expRef);
    int r;
    int seen;
    r = $random(seed);
    chkEn = 0;
    seen = ackCount;
    ackQ.push_back({ACTION_ACK_ENTRY, expLoop, expRef});
    @(negedge coreClk);
    actionPulse = 1'b1;
    actionSpecWord = {hwFormat, 8'h00, lowByte};
    loopChannel = r[4:0];
    @(negedge coreClk);
    actionPulse = 1'b0;
    for (int i = 0; i < ACK_LATENCY_MAX + 4 && ackCount == seen; i++) @(negedge coreClk);
    check("acknowledge", ackCount != seen, 1'b1);
    if (!expRef) begin
      curLoop = expLoop;
      curChan = r[4:0];
    end
    chkEn = 1;
    repeat (300) @(posedge txBitClock);  // more than one frame, so every slot is seen
    $display("step %h done", lowByte);
  endtask : act

  // ****************************************************
  // drivers and watchers
  // ****************************************************
  // formatter never stopped
  // formatter traffic changes on the falling link edge
  always @(negedge txBitClock) begin
    fr = $random(seed);
    formatterTxBit <= fr[0];
  end

  // acknowledge contents
  // every queue write is matched against the oldest note; a stuck strobe shows as an extra write
  always @(posedge coreClk) begin
    #1;
    if (eventQueueValid === 1'b1 || irqOut === 1'b1) begin
      check("irq with entry", irqOut, eventQueueValid);
      check("acknowledge noted", ackQ.size() != 0, 1'b1);
      if (ackQ.size() != 0) begin
        expNote = ackQ.pop_front();
        check("entry", eventQueueEntry, expNote[35:4]);
        check("loop state", loopState, expNote[3:1]);
        check("refused", loopRefused, expNote[0]);
      end
      ackCount++;
    end
  end

  // whole bits
  // own slot position and rx synchroniser; checks wait a few edges after each change settles
  always @(posedge txBitClock) begin
    fmt = formatterTxBit;
    rxd = rxS2;
    // the slot counter restarts on the edge after the synced pulse, so use the old position
    hit = pos[7:3] == curChan;
    pos = syncS2 ? 8'h00 : pos + 8'h01;
    syncS2 = syncS1;
    syncS1 = txSyncPulse;
    rxS2 = rxS1;
    rxS1 = serialRxPin;
    expOut = route(curLoop, fmt, rxd, hit);
    settle = chkEn ? settle + 1 : 0;
    #1;
    if (settle > 4) begin
      check("tx pin", serialTxPin, expOut[1]);
      check("rx path", rxPathBit, expOut[0]);
    end
  end

  // watchdog: the whole sequence needs about 200 us
  initial begin
    #400000;
    numErrors++;
    $display("Error watchdog expired");
    test_done();
  end

  // ****************************************************
  // main sequence
  // ****************************************************
  // close test open
  initial begin
    reset = 1'b1;
    actionPulse = 1'b0;
    actionSpecWord = 32'h00000000;
    loopChannel = 5'h00;
    formatterTxBit = 1'b0;
    repeat (3) @(negedge coreClk);  // three core cycles; the first link edge falls inside them
    reset = 1'b0;
    check("entry after reset", eventQueueEntry, ENTRY_RESET);
    hwFormat = 16'($random(seed));
    repeat (1100) @(posedge txBitClock);
    act(8'h00, LOOP_NONE, 1'b0);
    act(8'h08, LOOP_INT_FULL, 1'b0);
    act(8'h28, LOOP_INT_CHAN, 1'b0);
    act(8'h08, LOOP_INT_CHAN, 1'b1);
    act(8'h00, LOOP_NONE, 1'b0);
    act(8'h10, LOOP_EXT_FULL, 1'b0);
    act(8'h28, LOOP_EXT_FULL, 1'b1);
    act(8'h30, LOOP_EXT_CHAN, 1'b0);
    act(8'h38, LOOP_EXT_CHAN, 1'b1);
    act(8'h20, LOOP_EXT_CHAN, 1'b1);
    // hardware reset in mid-loop
    @(negedge coreClk);
    chkEn = 0;
    reset = 1'b1;
    repeat (16) @(negedge coreClk);
    reset = 1'b0;
    curLoop = LOOP_NONE;
    check("loop after reset", loopState, LOOP_NONE);
    check("refusal after reset", loopRefused, 1'b0);
    repeat (1100) @(posedge txBitClock);
    act(8'h18, LOOP_NONE, 1'b1);
    act(8'h28, LOOP_INT_CHAN, 1'b0);
    test_done();
  end
endmodule : shtl_test_loops_test

`default_nettype wire

// File: verilog/shtl_pkg.sv
// shared constants and types for the serial highway test loops
`default_nettype none

package shtl_pkg;

  // ****************************************************
  // loop selection bits of the action specification
  // ****************************************************
  localparam int LOOP_FIELD_LSB = 3;  // internal_wrap_select at bit 3, external at 4, single channel at 5
  localparam int LOOP_FIELD_W = 3;

  // three loop bits, single channel wrap on top
  typedef struct packed {
    logic singleChannelWrap;
    logic externalWrapSelect;
    logic internalWrapSelect;
  } shtl_loop_t;

  localparam shtl_loop_t LOOP_NONE = 3'h0;     // low byte 00
  localparam shtl_loop_t LOOP_INT_FULL = 3'h1; // low byte 08
  localparam shtl_loop_t LOOP_EXT_FULL = 3'h2; // low byte 10
  localparam shtl_loop_t LOOP_INT_CHAN = 3'h5; // low byte 28
  localparam shtl_loop_t LOOP_EXT_CHAN = 3'h6; // low byte 30

  // ****************************************************
  // highway geometry and event entries
  // ****************************************************
  localparam int SLOT_BITS = 8;
  localparam int SLOT_COUNT = 32;
  localparam int CHAN_W = 5;
  localparam logic [31:0] ACTION_ACK_ENTRY = 32'h90008000;
  localparam logic [31:0] ENTRY_RESET = 32'h00000000;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 5'h00;
  // bound on the request/acknowledge round trip, in core cycles
  localparam int ACK_LATENCY_MAX = 40;

  // loop setting handed to the link side
  typedef struct packed {
    shtl_loop_t loop;
    logic [CHAN_W-1:0] channel;
  } shtl_cfg_t;

  // core side handshake states
  typedef enum logic [1:0] {
    CORE_IDLE,
    CORE_WAIT,
    CORE_DONE
  } shtl_core_state_t;

endpackage : shtl_pkg

`default_nettype wire

// File: verilog/shtl_slot_counter.sv
// bit and time slot position on the highway, aligned by the sync pulse
`default_nettype none

module shtl_slot_counter
  import shtl_pkg::*;
#(
  parameter int BITS_PER_SLOT = SLOT_BITS,
  parameter int SLOTS = SLOT_COUNT
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // frame alignment
  input wire logic syncPulse,
  // current position
  output logic [$clog2(SLOTS)-1:0] slotIndex
);

  logic [$clog2(BITS_PER_SLOT)-1:0] bitIndex_q;
  logic [$clog2(SLOTS)-1:0] slot_q;

  // sync pulse marks bit 0 of slot 0; free counting in between
  always_ff @(posedge clk) begin
    if (reset || syncPulse) begin
      bitIndex_q <= '0;
      slot_q <= '0;
    end else if (bitIndex_q == ($clog2(BITS_PER_SLOT))'(BITS_PER_SLOT - 1)) begin
      bitIndex_q <= '0;
      slot_q <= slot_q + 1'b1;
    end else begin
      bitIndex_q <= bitIndex_q + 1'b1;
    end
  end

  assign slotIndex = slot_q;

endmodule : shtl_slot_counter

`default_nettype wire

// File: verilog/shtl_sync.sv
// two flip-flop synchroniser for levels entering a clock domain
`default_nettype none

module shtl_sync #(
  parameter int WIDTH = 1
) (
  // clock
  input wire logic clk,
  // crossing level and its synchronised copy
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // no reset so the first stage stays a pure flop pair
  always_ff @(posedge clk) begin
    meta_q <= d;
    q <= meta_q;
  end

endmodule : shtl_sync

`default_nettype wire

// File: verilog/shtl_test_loops.sv
// loopback control for the serial highway: loop selection, crossing, bit routing
`default_nettype none

// Behaviour
// - four loops: internal/external, whole or channel
// - internal full: transmit fed back, rx pin ignored
// - internal channel loop returns only one channel
// - external full: rx pin routed to tx pin
// - external channel loop returns only one channel
// - channel loops act in that slot only
// - loop bit codes 08, 28, 10
// - codes 30 and 00; other codes refused
// - all loop bits zero opens the loop
// - full to channel same side by software
// - action pulse applies setting, then acknowledge entry
// - acknowledge written to queue with interrupt pulse
module shtl_test_loops
  import shtl_pkg::*;
(
  // core clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // host action request
  input wire logic actionPulse,
  input wire logic [31:0] actionSpecWord,
  input wire logic [CHAN_W-1:0] loopChannel,
  // event queue and status
  output logic eventQueueValid,
  output logic [31:0] eventQueueEntry,
  output logic irqOut,
  output logic [LOOP_FIELD_W-1:0] loopState,
  output logic loopRefused,
  // link clock and serial pins
  input wire logic txBitClock,
  input wire logic txSyncPulse,
  input wire logic serialRxPin,
  // formatter and deformatter side, on the link clock
  input wire logic formatterTxBit,
  output logic serialTxPin,
  output logic rxPathBit
);

  // ****************************************************
  // change legality
  // ****************************************************

  // allowed without hardware reset: open, close from none, repeat, full to channel same side
  function automatic logic change_allowed(input shtl_loop_t cur, input shtl_loop_t nxt);
    logic ok;
    ok = 1'b0;
    if (nxt == LOOP_NONE) begin
      ok = 1'b1;
    end else if (nxt != LOOP_INT_FULL && nxt != LOOP_INT_CHAN && nxt != LOOP_EXT_FULL && nxt != LOOP_EXT_CHAN) begin
      ok = 1'b0;
    end else if (cur == LOOP_NONE || cur == nxt) begin
      ok = 1'b1;
    end else if ((cur == LOOP_INT_FULL && nxt == LOOP_INT_CHAN) || (cur == LOOP_EXT_FULL && nxt == LOOP_EXT_CHAN)) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : change_allowed

  // ****************************************************
  // core side: action handling
  // ****************************************************

  shtl_core_state_t state_q;
  shtl_cfg_t cfg_q;
  shtl_loop_t activeLoop_q;
  logic reqToggle_q;
  logic ackSync;
  logic eventValid_q;
  logic [31:0] entry_q;
  logic irq_q;
  logic refused_q;
  shtl_loop_t newLoop;
  logic accept;

  // loop bits sit at bits 5..3
  assign newLoop = actionSpecWord[LOOP_FIELD_LSB +: LOOP_FIELD_W];
  // pulses during a pending handshake are dropped; one action at a time
  assign accept = actionPulse && state_q == CORE_IDLE;

  // handshake sequencing
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= CORE_IDLE;
      reqToggle_q <= 1'b0;
    end else begin
      case (state_q)
        CORE_IDLE: begin
          if (accept) begin
            state_q <= CORE_WAIT;
            reqToggle_q <= ~reqToggle_q;
          end
        end
        CORE_WAIT: begin
          if (ackSync == reqToggle_q) begin
            state_q <= CORE_DONE;
          end
        end
        CORE_DONE: begin
          state_q <= CORE_IDLE;
        end
        default: begin
          state_q <= CORE_IDLE;
        end
      endcase
    end
  end

  // setting held stable while the link side copies it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg_q <= '{loop: LOOP_NONE, channel: CHAN_RESET};
      refused_q <= 1'b0;
    end else if (accept) begin
      // zero loop bits open the loop
      if (change_allowed(cfg_q.loop, newLoop)) begin
        cfg_q <= '{loop: newLoop, channel: loopChannel};
        refused_q <= 1'b0;
      end else begin
        // illegal change keeps the old loop
        refused_q <= 1'b1;
      end
    end
  end

  // committed loop is shown only once the link side has applied it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      activeLoop_q <= LOOP_NONE;
    end else if (state_q == CORE_WAIT && ackSync == reqToggle_q) begin
      activeLoop_q <= cfg_q.loop;
    end
  end

  // acknowledge entry after the setting took effect
  always_ff @(posedge core_clk) begin
    if (reset) begin
      eventValid_q <= 1'b0;
      entry_q <= ENTRY_RESET;
      irq_q <= 1'b0;
    end else begin
      eventValid_q <= state_q == CORE_DONE;
      irq_q <= state_q == CORE_DONE;
      if (state_q == CORE_DONE) begin
        entry_q <= ACTION_ACK_ENTRY;
      end
    end
  end

  assign eventQueueValid = eventValid_q;
  assign eventQueueEntry = entry_q;
  assign irqOut = irq_q;
  assign loopState = activeLoop_q;
  assign loopRefused = refused_q;

  // ****************************************************
  // crossings between the domains
  // ****************************************************

  logic linkReset;
  logic reqSync;
  logic rxPinSync;
  logic syncPulseSync;
  logic ackToggle_q;

  shtl_sync #(.WIDTH(1)) u_resetSync (.clk(txBitClock), .d(reset), .q(linkReset));
  shtl_sync #(.WIDTH(1)) u_reqSync (.clk(txBitClock), .d(reqToggle_q), .q(reqSync));
  shtl_sync #(.WIDTH(1)) u_ackSync (.clk(core_clk), .d(ackToggle_q), .q(ackSync));
  shtl_sync #(.WIDTH(1)) u_rxSync (.clk(txBitClock), .d(serialRxPin), .q(rxPinSync));
  shtl_sync #(.WIDTH(1)) u_spSync (.clk(txBitClock), .d(txSyncPulse), .q(syncPulseSync));

  // ****************************************************
  // link side: setting and bit routing
  // ****************************************************

  shtl_cfg_t linkCfg_q;
  logic [CHAN_W-1:0] slotIndex;
  logic inSlot;
  logic txNext;
  logic rxNext;
  logic txPin_q;
  logic rxBit_q;

  shtl_slot_counter #(.BITS_PER_SLOT(SLOT_BITS), .SLOTS(SLOT_COUNT)) u_slots (
    .clk(txBitClock),
    .reset(linkReset),
    .syncPulse(syncPulseSync),
    .slotIndex(slotIndex)
  );

  // new setting takes hold on a bit clock edge
  always_ff @(posedge txBitClock) begin
    if (linkReset) begin
      linkCfg_q <= '{loop: LOOP_NONE, channel: CHAN_RESET};
      ackToggle_q <= 1'b0;
    end else if (reqSync != ackToggle_q) begin
      linkCfg_q <= cfg_q;
      ackToggle_q <= reqSync;
    end
  end

  // channel loops touch their own slot only
  assign inSlot = slotIndex == linkCfg_q.channel;

  always_comb begin
    txNext = formatterTxBit;
    rxNext = rxPinSync;
    case (linkCfg_q.loop)
      LOOP_INT_FULL: begin
        rxNext = formatterTxBit;
      end
      LOOP_INT_CHAN: begin
        rxNext = inSlot ? formatterTxBit : rxPinSync;
      end
      LOOP_EXT_FULL: begin
        txNext = rxPinSync;
      end
      LOOP_EXT_CHAN: begin
        txNext = inSlot ? rxPinSync : formatterTxBit;
      end
      default: begin
        txNext = formatterTxBit;
      end
    endcase
  end

  // registered pins; a whole bit always leaves, never a glitch
  always_ff @(posedge txBitClock) begin
    if (linkReset) begin
      txPin_q <= 1'b0;
      rxBit_q <= 1'b0;
    end else begin
      txPin_q <= txNext;
      rxBit_q <= rxNext;
    end
  end

  assign serialTxPin = txPin_q;
  assign rxPathBit = rxBit_q;

  // ****************************************************
  // checks
  // ****************************************************

  // acknowledge window bound, local so the delay range stays a plain constant
  localparam int ACK_WINDOW = ACK_LATENCY_MAX;

  property p_intFullEcho;
    @(posedge txBitClock) disable iff (linkReset)
      linkCfg_q.loop == LOOP_INT_FULL |=> rxPathBit == $past(formatterTxBit);
  endproperty
  a_intFullEcho: assert property (p_intFullEcho) else $error("internal loop lost tx bit");

  property p_intFullPin;
    @(posedge txBitClock) disable iff (linkReset)
      linkCfg_q.loop == LOOP_INT_FULL |=> serialTxPin == $past(formatterTxBit);
  endproperty
  a_intFullPin: assert property (p_intFullPin) else $error("internal loop stopped driving tx pin");

  property p_intChanOther;
    @(posedge txBitClock) disable iff (linkReset)
      linkCfg_q.loop == LOOP_INT_CHAN && !inSlot |=> rxPathBit == $past(rxPinSync);
  endproperty
  a_intChanOther: assert property (p_intChanOther) else $error("other channel disturbed by loop");

  property p_intChanSlot;
    @(posedge txBitClock) disable iff (linkReset)
      linkCfg_q.loop == LOOP_INT_CHAN && inSlot |=> rxPathBit == $past(formatterTxBit);
  endproperty
  a_intChanSlot: assert property (p_intChanSlot) else $error("looped channel not fed back");

  property p_extFull;
    @(posedge txBitClock) disable iff (linkReset)
      linkCfg_q.loop == LOOP_EXT_FULL |=> serialTxPin == $past(rxPinSync) && rxPathBit == $past(rxPinSync);
  endproperty
  a_extFull: assert property (p_extFull) else $error("external loop not routing rx to tx");

  property p_extChanSlot;
    @(posedge txBitClock) disable iff (linkReset)
      linkCfg_q.loop == LOOP_EXT_CHAN && inSlot |=> serialTxPin == $past(rxPinSync);
  endproperty
  a_extChanSlot: assert property (p_extChanSlot) else $error("looped channel not returned");

  property p_extChanRx;
    @(posedge txBitClock) disable iff (linkReset)
      linkCfg_q.loop == LOOP_EXT_CHAN |=> rxPathBit == $past(rxPinSync);
  endproperty
  a_extChanRx: assert property (p_extChanRx) else $error("external channel loop disturbed receive");

  property p_extChanOther;
    @(posedge txBitClock) disable iff (linkReset)
      linkCfg_q.loop == LOOP_EXT_CHAN && !inSlot |=> serialTxPin == $past(formatterTxBit);
  endproperty
  a_extChanOther: assert property (p_extChanOther) else $error("loop acted outside its slot");

  property p_ackFollows;
    @(posedge core_clk) disable iff (reset)
      accept |-> ##[3:ACK_WINDOW] eventQueueValid;
  endproperty
  a_ackFollows: assert property (p_ackFollows) else $error("no acknowledge after action pulse");

  property p_ackEntry;
    @(posedge core_clk) disable iff (reset)
      eventQueueValid |-> irqOut && eventQueueEntry == ACTION_ACK_ENTRY ##1 !irqOut;
  endproperty
  a_ackEntry: assert property (p_ackEntry) else $error("acknowledge entry or irq wrong");

  property p_resetNone;
    @(posedge core_clk) $past(reset) |-> loopState == LOOP_NONE && cfg_q.loop == LOOP_NONE;
  endproperty
  a_resetNone: assert property (p_resetNone) else $error("reset left a loop closed");

  property p_openLoop;
    @(posedge core_clk) disable iff (reset)
      accept && newLoop == LOOP_NONE |=> cfg_q.loop == LOOP_NONE && !loopRefused;
  endproperty
  a_openLoop: assert property (p_openLoop) else $error("zero loop bits did not open loop");

  property p_badChange;
    @(posedge core_clk) disable iff (reset)
      accept && !change_allowed(cfg_q.loop, newLoop) |=> loopRefused && cfg_q.loop == $past(cfg_q.loop);
  endproperty
  a_badChange: assert property (p_badChange) else $error("illegal loop change applied");

  property p_upgrade;
    @(posedge core_clk) disable iff (reset)
      accept && cfg_q.loop == LOOP_INT_FULL && newLoop == LOOP_INT_CHAN |=> cfg_q.loop == LOOP_INT_CHAN;
  endproperty
  a_upgrade: assert property (p_upgrade) else $error("full to channel change refused");

endmodule : shtl_test_loops

`default_nettype wire
